// File: power_mode_cfg.svh
// Constants for the power mode configuration block: field positions,
// register offsets, reset values and timing counts.
// Assumes inclusion by bare name from the controller and the testbench modules.
`ifndef POWER_MODE_CFG_SVH
`define POWER_MODE_CFG_SVH

// ****************************************
// Register map
// ****************************************
`define ADDR_POWER_CONFIGURATION 4'h0
`define ADDR_MODE_COMMAND        4'h4
`define ADDR_MODE_STATUS         4'h8
`define POWER_CONFIGURATION_RESET 16'h2982
`define POWER_CONFIGURATION_MASK  16'h3FFF

// ****************************************
// Field positions
// ****************************************
`define BIT_DEEP_SLEEP_OVERTEMP  13
`define BIT_SHUTDOWN_WAIT        12
`define BIT_CHARGER_WAKE         11
`define BIT_KEEP_REGULATORS      10
`define BIT_KEEP_SLOW_OSC        9
`define BIT_SLEEP_DEFAULT        8
`define BIT_OVERTEMP_SHUTDOWN    7
`define BIT_FAST_CONVERSION      6
`define BIT_BAL_SLOW_HI          5
`define BIT_BAL_SLOW_LO          4
`define BIT_SCAN_SLOW_HI         3
`define BIT_SCAN_SLOW_LO         2
`define BIT_WAKE_PERIOD_HI       1
`define BIT_WAKE_PERIOD_LO       0

// Command word bits
`define CMD_SLEEP_ENABLE   0
`define CMD_SLEEP_DISABLE  1
`define CMD_ENTER_DEEP     2
`define CMD_EXIT_DEEP      3

// ****************************************
// Timing, 10 MHz clock
// ****************************************
`define CLK_PERIOD_NS      100
`define CONV_SLOW_US       3000
`define CONV_FAST_US       1500
`define CONV_SLOW_CYCLES   ((`CONV_SLOW_US * 1000) / `CLK_PERIOD_NS)
`define CONV_FAST_CYCLES   ((`CONV_FAST_US * 1000) / `CLK_PERIOD_NS)
`define WAKE_BASE_MS       6
`define WAKE_BASE_CYCLES   ((`WAKE_BASE_MS * 1000000) / `CLK_PERIOD_NS)

`endif

// File: power_mode_pkg.sv
// Types shared by the power mode configuration block.
// Assumes the constants header sits in the same folder.
package power_mode_pkg;
	// Operating mode of the controller
	typedef enum logic [2:0] {
		MODE_NORMAL   = 3'b000,
		MODE_DEEP     = 3'b001,
		MODE_SHUTDOWN = 3'b010,
		MODE_LD_WAIT  = 3'b011
	} mode_t;
endpackage

// File: edge_sync_if.sv
// Interface carrying a pin level into the synchroniser and its rising edge out.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
interface edge_sync_if;
	logic raw;   // Asynchronous pin level
	logic level; // Filtered level
	logic rise;  // One-cycle rising edge pulse
	modport sync (input raw, output level, output rise);
	modport user (output raw, input level, input rise);
endinterface // edge_sync_if

// File: pin_edge_sync.sv
// Three-flop pin synchroniser with rising edge pulse.
// Assumes the pin is asynchronous to mclk_in.
`timescale 1ns/1ps
module pin_edge_sync (
	input  wire logic mclk_in,
	input  wire logic srst_in,
	edge_sync_if.sync port
);
	logic [2:0] stage_ff; // Stage 0 read only by stage 1
	logic       level_ff; // Accepted level
	logic       rise_ff;  // Edge pulse

	// ****************************************
	// Shift chain
	// ****************************************
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			stage_ff <= 3'h0;
		end else begin
			stage_ff <= {stage_ff[1:0], port.raw};
		end
	end

	// Level changes only once stages 1 and 2 agree
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			level_ff <= 1'b0;
			rise_ff  <= 1'b0;
		end else begin
			rise_ff <= 1'b0;
			if (stage_ff[2] == stage_ff[1] && stage_ff[1] != level_ff) begin
				level_ff <= stage_ff[1];
				rise_ff  <= stage_ff[1];
			end
		end
	end

	assign port.level = level_ff;
	assign port.rise  = rise_ff;
endmodule // pin_edge_sync

// File: power_mode_config.sv
// Power mode controller driven by the 16-bit power configuration word.
// Assumes a classic Wishbone master, asynchronous load-detect and
// over-temperature inputs, and a 10 MHz clock.
`timescale 1ns/1ps
`include "power_mode_cfg.svh"
module power_mode_config
	import power_mode_pkg::*;
(
	input  wire logic        mclk_in,          // System clock
	input  wire logic        srst_in,          // Synchronous reset
	input  wire logic        wb_cyc_in,        // Wishbone cycle
	input  wire logic        wb_stb_in,        // Wishbone strobe
	input  wire logic        wb_we_in,         // Write enable
	input  wire logic [3:0]  wb_adr_in,        // Byte address
	input  wire logic [3:0]  wb_sel_in,        // Byte selects
	input  wire logic [31:0] wb_dat_in,        // Write data
	output logic      [31:0] wb_dat_out,       // Read data
	output logic             wb_ack_out,       // Acknowledge
	input  wire logic        load_detect_pin_in,  // Charger attach pin
	input  wire logic        overtemp_in,         // On-chip overtemp detect
	input  wire logic        shutdown_req_in,     // Shutdown conditions met
	input  wire logic        balancing_in,        // Cell balancing active
	input  wire logic        first_aux_regulator_on_in,          // Requested first regulator state
	input  wire logic        second_aux_regulator_on_in,          // Requested second regulator state
	output logic             first_aux_regulator_out,
	output logic             second_aux_regulator_out,
	output logic             slow_oscillator_out,
	output logic             sleep_enable_out,
	output logic             deep_sleep_mode_out,
	output logic             shutdown_out,
	output logic             ld_wait_out,
	output logic [23:0]      conversion_cycles_out,   // Cycles per conversion
	output logic [1:0]       scan_slowdown_out,       // Active slowdown code
	output logic [3:0]       extra_current_meas_out,  // Current-only slots per loop
	output logic [23:0]      wake_period_cycles_out   // Sleep wake conversion period
);

	// ****************************************
	// Declarations
	// ****************************************
	logic [15:0] power_configuration_ff; // Configuration word
	logic        sleep_en_ff;            // Sleep-enable status flag
	logic        init_ff;                // High once the flag is loaded
	mode_t       mode_ff;                // Mode state
	mode_t       nxt_mode;               // Next mode
	logic        ack_ff;                 // Bus ack
	logic [31:0] rdata_ff;               // Bus read data
	logic        first_aux_regulator_ff;                // Regulator drives
	logic        second_aux_regulator_ff;
	logic        osc_ff;
	logic [23:0] conv_ff;
	logic [1:0]  slow_ff;
	logic [3:0]  extra_ff;
	logic [23:0] wake_ff;
	logic        bus_req;                // Fresh request this cycle
	logic        wr_cmd;                 // Command write strobe
	logic        cmd_sleep_en;
	logic        cmd_sleep_dis;
	logic        cmd_enter;
	logic        cmd_exit;
	logic        ot_level;
	logic        deep_ff, shut_ff, wait_ff; // Registered mode flags for the outputs

	edge_sync_if ld_if ();
	edge_sync_if ot_if ();

	// ****************************************
	// Pin synchronisers
	// ****************************************
	pin_edge_sync u_ld_sync (
		.mclk_in (mclk_in),
		.srst_in (srst_in),
		.port    (ld_if)
	);
	pin_edge_sync u_ot_sync (
		.mclk_in (mclk_in),
		.srst_in (srst_in),
		.port    (ot_if)
	);
	assign ld_if.raw = load_detect_pin_in;
	assign ot_if.raw = overtemp_in;
	assign ot_level  = ot_if.level;

	// Decode of a slowdown code into inserted current-only slots
	function automatic logic [3:0] slots_of(input logic [1:0] code);
		slots_of = 4'((4'h1 << code) - 4'h1);
	endfunction

	// ****************************************
	// Wishbone slave
	// ****************************************
	// Ack lasts one cycle and blocks the next request, so a held request answers every second cycle
	assign bus_req = wb_cyc_in && wb_stb_in && !ack_ff;
	assign wr_cmd  = bus_req && wb_we_in && wb_adr_in == `ADDR_MODE_COMMAND && wb_sel_in[0];
	assign cmd_sleep_en  = wr_cmd && wb_dat_in[`CMD_SLEEP_ENABLE];
	assign cmd_sleep_dis = wr_cmd && wb_dat_in[`CMD_SLEEP_DISABLE];
	assign cmd_enter     = wr_cmd && wb_dat_in[`CMD_ENTER_DEEP];
	assign cmd_exit      = wr_cmd && wb_dat_in[`CMD_EXIT_DEEP];

	// Ack and read data one cycle after the request; unmapped addresses read zero
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			ack_ff   <= 1'b0;
			rdata_ff <= 32'h0;
		end else begin
			ack_ff <= bus_req;
			if (bus_req && !wb_we_in) begin
				if (wb_adr_in == `ADDR_POWER_CONFIGURATION) begin
					rdata_ff <= {16'h0, power_configuration_ff};
				end else if (wb_adr_in == `ADDR_MODE_STATUS) begin
					rdata_ff <= {26'h0, ot_level, sleep_en_ff, 1'b0, mode_ff};
				end else begin
					rdata_ff <= 32'h0;
				end
			end
		end
	end

	// Configuration word write, byte lanes honoured
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			power_configuration_ff <= `POWER_CONFIGURATION_RESET;
		end else if (bus_req && wb_we_in && wb_adr_in == `ADDR_POWER_CONFIGURATION) begin
			if (wb_sel_in[0]) begin
				power_configuration_ff[7:0] <= wb_dat_in[7:0];
			end
			if (wb_sel_in[1]) begin
				power_configuration_ff[15:8] <= wb_dat_in[15:8] & 8'(`POWER_CONFIGURATION_MASK >> 8);
			end
		end
	end

	// ****************************************
	// Sleep-enable flag
	// ****************************************
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			sleep_en_ff <= 1'b0;
			init_ff     <= 1'b0;
		end else if (!init_ff) begin
			sleep_en_ff <= power_configuration_ff[`BIT_SLEEP_DEFAULT];
			init_ff     <= 1'b1;
		end else if (cmd_sleep_en) begin
			sleep_en_ff <= 1'b1;
		end else if (cmd_sleep_dis) begin
			sleep_en_ff <= 1'b0;
		end
	end

	// ****************************************
	// Mode state machine
	// ****************************************
	// Next mode from events and configuration
	always_comb begin
		nxt_mode = mode_ff;
		case (mode_ff)
			MODE_NORMAL: begin
				if (shutdown_req_in || (ot_level && power_configuration_ff[`BIT_OVERTEMP_SHUTDOWN])) begin
					nxt_mode = MODE_SHUTDOWN;
				end else if (cmd_enter) begin
					nxt_mode = MODE_DEEP;
				end
			end
			MODE_DEEP: begin
				if (ot_level && power_configuration_ff[`BIT_DEEP_SLEEP_OVERTEMP]) begin
					nxt_mode = MODE_SHUTDOWN;
				end else if (shutdown_req_in) begin
					nxt_mode = MODE_SHUTDOWN;
				end else if (cmd_exit) begin
					nxt_mode = MODE_NORMAL;
				end else if (ld_if.rise && power_configuration_ff[`BIT_CHARGER_WAKE]) begin
					nxt_mode = MODE_NORMAL;
				end
			end
			MODE_SHUTDOWN: begin
				if (power_configuration_ff[`BIT_SHUTDOWN_WAIT]) begin
					nxt_mode = MODE_LD_WAIT;
				end
			end
			MODE_LD_WAIT: begin
				if (ld_if.rise) begin
					nxt_mode = MODE_NORMAL;
				end
			end
			default: begin
				nxt_mode = MODE_NORMAL;
			end
		endcase
	end

	// Mode register and its output flags; shutdown is left by reset, or for the load-detect wait when bit 12 is set
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			mode_ff <= MODE_NORMAL;
			deep_ff <= 1'b0;
			shut_ff <= 1'b0;
			wait_ff <= 1'b0;
		end else begin
			mode_ff <= nxt_mode;
			deep_ff <= nxt_mode == MODE_DEEP;
			shut_ff <= nxt_mode == MODE_SHUTDOWN;
			wait_ff <= nxt_mode == MODE_LD_WAIT;
		end
	end

	// ****************************************
	// Regulators and oscillator
	// ****************************************
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			first_aux_regulator_ff <= 1'b0;
			second_aux_regulator_ff <= 1'b0;
			osc_ff  <= 1'b1;
		end else begin
			if (nxt_mode == MODE_DEEP) begin
				if (mode_ff != MODE_DEEP && !power_configuration_ff[`BIT_KEEP_REGULATORS]) begin
					first_aux_regulator_ff <= 1'b0;
					second_aux_regulator_ff <= 1'b0;
				end
				osc_ff <= power_configuration_ff[`BIT_KEEP_SLOW_OSC];
			end else if (nxt_mode == MODE_NORMAL) begin
				first_aux_regulator_ff <= first_aux_regulator_on_in;
				second_aux_regulator_ff <= second_aux_regulator_on_in;
				osc_ff  <= 1'b1;
			end else begin
				first_aux_regulator_ff <= 1'b0;
				second_aux_regulator_ff <= 1'b0;
				osc_ff  <= 1'b0;
			end
		end
	end

	// ****************************************
	// Measurement settings
	// ****************************************
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			conv_ff  <= 24'h0;
			slow_ff  <= 2'h0;
			extra_ff <= 4'h0;
			wake_ff  <= 24'h0;
		end else begin
			conv_ff <= power_configuration_ff[`BIT_FAST_CONVERSION] ? 24'(`CONV_FAST_CYCLES) : 24'(`CONV_SLOW_CYCLES);
			if (balancing_in) begin
				slow_ff  <= power_configuration_ff[`BIT_BAL_SLOW_HI:`BIT_BAL_SLOW_LO];
				extra_ff <= slots_of(power_configuration_ff[`BIT_BAL_SLOW_HI:`BIT_BAL_SLOW_LO]);
			end else begin
				slow_ff  <= power_configuration_ff[`BIT_SCAN_SLOW_HI:`BIT_SCAN_SLOW_LO];
				extra_ff <= slots_of(power_configuration_ff[`BIT_SCAN_SLOW_HI:`BIT_SCAN_SLOW_LO]);
			end
			wake_ff <= 24'(24'(`WAKE_BASE_CYCLES) << (2'h3 - power_configuration_ff[`BIT_WAKE_PERIOD_HI:`BIT_WAKE_PERIOD_LO]));
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign wb_ack_out               = ack_ff;
	assign wb_dat_out               = rdata_ff;
	assign first_aux_regulator_out  = first_aux_regulator_ff;
	assign second_aux_regulator_out = second_aux_regulator_ff;
	assign slow_oscillator_out      = osc_ff;
	assign sleep_enable_out         = sleep_en_ff;
	assign deep_sleep_mode_out      = deep_ff;
	assign shutdown_out             = shut_ff;
	assign ld_wait_out              = wait_ff;
	assign conversion_cycles_out    = conv_ff;
	assign scan_slowdown_out        = slow_ff;
	assign extra_current_meas_out   = extra_ff;
	assign wake_period_cycles_out   = wake_ff;

	// ****************************************
	// Assertions
	// ****************************************
	chk_deep_overtemp: assert property (@(posedge mclk_in) disable iff (srst_in)
		mode_ff == MODE_DEEP && ot_level && power_configuration_ff[13] |=> mode_ff == MODE_SHUTDOWN)
		else $error("deep overtemp did not shut down");
	chk_shutdown_wait: assert property (@(posedge mclk_in) disable iff (srst_in)
		mode_ff == MODE_SHUTDOWN && power_configuration_ff[12] |=> mode_ff == MODE_LD_WAIT)
		else $error("shutdown not replaced by wait");
	chk_no_ld_wake: assert property (@(posedge mclk_in) disable iff (srst_in)
		mode_ff == MODE_DEEP && !power_configuration_ff[11] && !cmd_exit && !ot_level && !shutdown_req_in
		|=> mode_ff == MODE_DEEP)
		else $error("deep sleep left without command");
	chk_reg_off_deep: assert property (@(posedge mclk_in) disable iff (srst_in)
		mode_ff == MODE_NORMAL && nxt_mode == MODE_DEEP && !power_configuration_ff[10]
		|=> !first_aux_regulator_ff && !second_aux_regulator_ff)
		else $error("regulators on in deep sleep");
	chk_osc_deep: assert property (@(posedge mclk_in) disable iff (srst_in)
		nxt_mode == MODE_DEEP |=> osc_ff == $past(power_configuration_ff[9]))
		else $error("oscillator wrong in deep sleep");
	chk_sleep_default: assert property (@(posedge mclk_in) disable iff (srst_in)
		!init_ff |=> sleep_en_ff == $past(power_configuration_ff[8]))
		else $error("sleep flag default wrong");
	chk_sleep_cmd: assert property (@(posedge mclk_in) disable iff (srst_in)
		init_ff && cmd_sleep_dis && !cmd_sleep_en |=> !sleep_en_ff)
		else $error("sleep disable ignored");
	chk_overtemp_sd: assert property (@(posedge mclk_in) disable iff (srst_in)
		mode_ff == MODE_NORMAL && ot_level && power_configuration_ff[7] |=> mode_ff == MODE_SHUTDOWN)
		else $error("overtemp shutdown missed");
	chk_conv_time: assert property (@(posedge mclk_in) disable iff (srst_in)
		power_configuration_ff[6] ##1 power_configuration_ff[6] |-> conv_ff == 24'(`CONV_FAST_CYCLES))
		else $error("fast conversion count wrong");
	chk_reserved_zero: assert property (@(posedge mclk_in) disable iff (srst_in)
		power_configuration_ff[15:14] == 2'h0)
		else $error("reserved bits set");
	cov_deep_wake: cover property (@(posedge mclk_in) mode_ff == MODE_DEEP ##1 mode_ff == MODE_NORMAL);
	cov_ld_wait: cover property (@(posedge mclk_in) mode_ff == MODE_LD_WAIT ##1 mode_ff == MODE_NORMAL);
	cov_sleep_off: cover property (@(posedge mclk_in) sleep_en_ff ##1 !sleep_en_ff);
endmodule // power_mode_config

// File: power_mode_config_tb.sv
// Self-checking bench for the power mode configuration block.
// Assumes the constants header and package are compiled first; one 10 MHz clock.
`timescale 1ns/1ps
`include "power_mode_cfg.svh"
module testbench;
	// ****************
	// Signals
	// ****************
	logic        mclk_in, srst_in, wb_cyc_in, wb_stb_in, wb_we_in, wb_ack_out;
	logic [3:0]  wb_adr_in, wb_sel_in, extra_current_meas_out;
	logic [31:0] wb_dat_in, wb_dat_out, rdata;
	logic        load_detect_pin_in, overtemp_in, shutdown_req_in, balancing_in, first_aux_regulator_on_in, second_aux_regulator_on_in;
	logic        first_aux_regulator_out, second_aux_regulator_out, slow_oscillator_out, sleep_enable_out;
	logic        deep_sleep_mode_out, shutdown_out, ld_wait_out;
	logic [23:0] conversion_cycles_out, wake_period_cycles_out;
	logic [1:0]  scan_slowdown_out;
	int          n_mismatch, checked;
	localparam logic [3:0] CFG = `ADDR_POWER_CONFIGURATION;
	localparam logic [3:0] CMD = `ADDR_MODE_COMMAND;
	localparam logic [3:0] STS = `ADDR_MODE_STATUS;

	power_mode_config u_dut (
		.mclk_in, .srst_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in,
		.wb_dat_out, .wb_ack_out, .load_detect_pin_in, .overtemp_in, .shutdown_req_in, .balancing_in,
		.first_aux_regulator_on_in, .second_aux_regulator_on_in, .first_aux_regulator_out, .second_aux_regulator_out,
		.slow_oscillator_out, .sleep_enable_out, .deep_sleep_mode_out, .shutdown_out, .ld_wait_out,
		.conversion_cycles_out, .scan_slowdown_out, .extra_current_meas_out, .wake_period_cycles_out
	);

	// Free-running clock, 100 ns period
	initial begin
		mclk_in = 1'b0;
		forever #50 mclk_in = ~mclk_in;
	end

	// ****************
	// Helpers
	// ****************
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Single-bit compare
	task automatic chb(input logic seen, input logic exp);
		chk({31'h0, seen}, {31'h0, exp});
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk_in);
	endtask

	// Classic Wishbone cycle; request held until ack is sampled
	task automatic xfer(input logic [3:0] adr, input logic we, input logic [3:0] sel, input logic [31:0] dat);
		int n;
		n = 0;
		@(posedge mclk_in);
		wb_cyc_in <= 1'b1;
		wb_stb_in <= 1'b1;
		wb_we_in  <= we;
		wb_adr_in <= adr;
		wb_dat_in <= dat;
		wb_sel_in <= sel;
		do begin
			@(posedge mclk_in);
			n++;
			// A silent slave ends the run
			if (n > 20) begin
				n_mismatch++;
				wrap_up();
			end
		end while (wb_ack_out !== 1'b1);
		rdata = wb_dat_out;
		wb_cyc_in <= 1'b0;
		wb_stb_in <= 1'b0;
		wb_we_in  <= 1'b0;
	endtask

	task automatic wr(input logic [3:0] adr, input logic [31:0] dat);
		xfer(adr, 1'b1, 4'hF, dat);
	endtask

	// Write with chosen byte lanes
	task automatic wr_sel(input logic [3:0] adr, input logic [3:0] sel, input logic [31:0] dat);
		xfer(adr, 1'b1, sel, dat);
	endtask

	task automatic rd(input logic [3:0] adr);
		xfer(adr, 1'b0, 4'hF, 32'h0);
	endtask

	task automatic do_reset();
		overtemp_in <= 1'b0;
		shutdown_req_in <= 1'b0;
		srst_in <= 1'b1;
		cyc(20);
		srst_in <= 1'b0;
		cyc(2);
	endtask

	// Load-detect rising edge; long enough to pass the synchroniser
	task automatic pulse_ld();
		load_detect_pin_in <= 1'b1;
		cyc(8);
		load_detect_pin_in <= 1'b0;
		cyc(6);
	endtask

	// Deep sleep entry and exit under a given configuration
	task automatic deep_case(input logic [15:0] cfg);
		wr(CFG, {16'h0, cfg});
		first_aux_regulator_on_in <= 1'b1;
		second_aux_regulator_on_in <= 1'b1;
		cyc(3);
		wr(CMD, 32'h1 << `CMD_ENTER_DEEP);
		cyc(2);
		chb(deep_sleep_mode_out, 1'b1);
		chb(first_aux_regulator_out, cfg[10]);
		chb(second_aux_regulator_out, cfg[10]);
		chb(slow_oscillator_out, cfg[9]);
		pulse_ld();
		chb(deep_sleep_mode_out, ~cfg[11]);
		wr(CMD, 32'h1 << `CMD_EXIT_DEEP);
		cyc(2);
		chb(deep_sleep_mode_out, 1'b0);
	endtask

	// ****************
	// Main sequence
	// ****************
	initial begin
		{srst_in, wb_cyc_in, wb_stb_in, wb_we_in} = 4'h8;
		{load_detect_pin_in, overtemp_in, shutdown_req_in, balancing_in, first_aux_regulator_on_in, second_aux_regulator_on_in} = 6'h00;
		wb_adr_in = 4'h0;
		wb_sel_in = 4'h0;
		wb_dat_in = 32'h0;
		n_mismatch = 0;
		checked = 0;
		do_reset();
		// Defaults after reset
		rd(CFG);
		chk(rdata, 32'h2982);
		chb(sleep_enable_out, 1'b1);
		chb(slow_oscillator_out, 1'b1);
		chk({8'h0, conversion_cycles_out}, `CONV_SLOW_CYCLES);
		rd(STS);
		chk(rdata & 32'h1F, 32'h10);
		// Reserved bits ignored; unmapped place reads zero, writes lost
		wr(CFG, 32'hFFFF);
		rd(CFG);
		chk(rdata, 32'h3FFF);
		wr(4'hC, 32'h0);
		rd(4'hC);
		chk(rdata, 32'h0);
		rd(CFG);
		chk(rdata, 32'h3FFF);
		cyc(2);
		chk({8'h0, conversion_cycles_out}, `CONV_FAST_CYCLES);
		// Only the selected upper lane is written, reserved bits still masked
		wr_sel(CFG, 4'h2, 32'hC100);
		rd(CFG);
		chk(rdata, 32'h01FF);
		// Every slowdown and wake code, balancing off and on
		for (int k = 0; k < 4; k++) begin
			wr(CFG, 32'h2900 | (k << 4) | ((3 - k) << 2) | k);
			balancing_in <= 1'b0;
			cyc(3);
			chk({30'h0, scan_slowdown_out}, 3 - k);
			chk({28'h0, extra_current_meas_out}, (1 << (3 - k)) - 1);
			chk({8'h0, wake_period_cycles_out}, `WAKE_BASE_CYCLES << (3 - k));
			balancing_in <= 1'b1;
			cyc(3);
			chk({30'h0, scan_slowdown_out}, k);
			chk({28'h0, extra_current_meas_out}, (1 << k) - 1);
		end
		balancing_in <= 1'b0;
		// Sleep-enable subcommands; a command without the low lane is ignored
		wr_sel(CMD, 4'h2, 32'h1 << `CMD_SLEEP_DISABLE);
		cyc(2);
		chb(sleep_enable_out, 1'b1);
		wr(CMD, 32'h1 << `CMD_SLEEP_DISABLE);
		cyc(2);
		chb(sleep_enable_out, 1'b0);
		rd(STS);
		chk(rdata & 32'h10, 32'h0);
		wr(CMD, 32'h1 << `CMD_SLEEP_ENABLE);
		cyc(2);
		chb(sleep_enable_out, 1'b1);
		// Deep sleep: host-only exit, then charger wake with kept supplies
		deep_case(16'h2182);
		deep_case(16'h2F82);
		// Overtemp ignored in deep sleep when disabled there
		wr(CFG, 32'h0982);
		wr(CMD, 32'h1 << `CMD_ENTER_DEEP);
		overtemp_in <= 1'b1;
		cyc(8);
		chb(shutdown_out, 1'b0);
		chb(deep_sleep_mode_out, 1'b1);
		rd(STS);
		chk(rdata & 32'h27, 32'h21);
		overtemp_in <= 1'b0;
		cyc(6);
		wr(CMD, 32'h1 << `CMD_EXIT_DEEP);
		// Severe overtemp path disabled in normal mode
		wr(CFG, 32'h2902);
		overtemp_in <= 1'b1;
		cyc(8);
		chb(shutdown_out, 1'b0);
		overtemp_in <= 1'b0;
		cyc(6);
		// Overtemp in deep sleep forces shutdown when enabled
		wr(CMD, 32'h1 << `CMD_ENTER_DEEP);
		overtemp_in <= 1'b1;
		cyc(8);
		chb(shutdown_out, 1'b1);
		do_reset();
		// Severe overtemp path enabled by default
		overtemp_in <= 1'b1;
		cyc(8);
		chb(shutdown_out, 1'b1);
		do_reset();
		// True shutdown, then the load-detect wait in its place
		shutdown_req_in <= 1'b1;
		cyc(3);
		chb(shutdown_out, 1'b1);
		chb(ld_wait_out, 1'b0);
		do_reset();
		wr(CFG, 32'h3982);
		shutdown_req_in <= 1'b1;
		cyc(4);
		chb(ld_wait_out, 1'b1);
		shutdown_req_in <= 1'b0;
		pulse_ld();
		chb(ld_wait_out, 1'b0);
		chb(shutdown_out, 1'b0);
		wrap_up();
	end

	// Cut a hang short
	initial begin
		repeat (90000) @(posedge mclk_in);
		n_mismatch++;
		wrap_up();
	end
endmodule // testbench
